// [temperature_fault_supervisor_consts.svh]
// constants of the temperature fault supervisor: command codes, resets, fields, timing
// assumes inclusion by bare name from the fault responder and supervisor design files
`ifndef TEMPERATURE_FAULT_SUPERVISOR_CONSTS_SVH
`define TEMPERATURE_FAULT_SUPERVISOR_CONSTS_SVH
`define CMD_OT_FAULT_THR    8'h4f
`define CMD_OT_FAULT_ACTION 8'h50
`define CMD_OT_WARN_THR     8'h51
`define CMD_UT_WARN_THR     8'h52
`define CMD_UT_FAULT_THR    8'h53
`define CMD_UT_FAULT_ACTION 8'h54
`define RST_OT_FAULT_THR    16'hebe8
`define RST_OT_WARN_THR     16'heb70
`define RST_UT_WARN_THR     16'he4e0
`define RST_UT_FAULT_THR    16'he490
`define RST_FAULT_ACTION    8'h80
`define ACT_MODE_HI         7
`define ACT_MODE_LO         6
`define ACT_RETRY_HI        5
`define ACT_RETRY_LO        3
`define ACT_TIME_HI         2
`define ACT_TIME_LO         0
`define RETRY_NONE          3'h0
`define RETRY_ENDLESS       3'h7
`define ST_OT_FAULT_BIT     7
`define ST_OT_WARN_BIT      6
`define ST_UT_WARN_BIT      5
`define ST_UT_FAULT_BIT     4
`define OT_RANGE_MIN_C      0
`define OT_RANGE_MAX_C      175
`define UT_RANGE_MIN_C      -55
`define UT_RANGE_MAX_C      25
`define FIXED_FRAC_BITS     16
`define CLK_PERIOD_NS       10
`define OT_TIME_UNIT_NS     1000000
`define UT_TIME_UNIT_NS     1000000
`endif

// [temp_supervisor_pkg.sv]
// types shared by the temperature fault supervisor and its fault responders
// assumes nothing beyond a SystemVerilog compiler
`default_nettype none
package temp_supervisor_pkg;
  typedef logic        [15:0] l11_word_type;
  typedef logic signed [47:0] fixed_temp_type;
  typedef enum logic [1:0] {
    act_continue  = 2'b00,
    act_delay_off = 2'b01,
    act_off_retry = 2'b10,
    act_hold_off  = 2'b11
  } action_mode_type;
  typedef enum logic [2:0] {
    st_run     = 3'b000,
    st_delay   = 3'b001,
    st_off     = 3'b011,
    st_wait    = 3'b010,
    st_hold    = 3'b100,
    st_latched = 3'b111
  } responder_state_type;
endpackage : temp_supervisor_pkg
`default_nettype wire

// [fault_responder.sv]
// one fault response sequencer: delay, disable, retry or hold per coded action byte
// assumes fault_active is a clean level and restart, start_ok are synchronous pulses
`default_nettype none
`include "temperature_fault_supervisor_consts.svh"
module fault_responder #(
  parameter int unsigned UNIT_CYCLES = 100000,
  parameter int          CNT_W       = 24
) (
  input  wire logic       clk,
  input  wire logic       reset,
  input  wire logic [7:0] action,
  input  wire logic       fault_active,
  input  wire logic       restart,
  input  wire logic       rail_disable,
  input  wire logic       other_latched,
  input  wire logic       start_ok,
  output var  logic       output_on,
  output var  logic       latched
);
  import temp_supervisor_pkg::*;
  responder_state_type state;
  responder_state_type next_state;
  logic [CNT_W-1:0]    timer;
  logic [CNT_W-1:0]    next_timer;
  logic [2:0]          attempts;
  logic [2:0]          next_attempts;
  wire action_mode_type  mode       = action_mode_type'(action[`ACT_MODE_HI:`ACT_MODE_LO]);
  wire logic [2:0]       retry_set  = action[`ACT_RETRY_HI:`ACT_RETRY_LO];
  wire logic [2:0]       time_set   = action[`ACT_TIME_HI:`ACT_TIME_LO];
  wire logic [CNT_W-1:0] span       = CNT_W'(time_set * UNIT_CYCLES);
  wire logic             timer_done = (timer == '0);
  wire logic             endless    = (retry_set == `RETRY_ENDLESS);
  wire logic             retry_left = endless || (attempts < retry_set);
  wire logic             stop_now   = rail_disable || other_latched;

  always_comb begin
    next_state    = state;
    next_timer    = timer_done ? timer : timer - 1'b1;
    next_attempts = attempts;
    unique case (state)
      st_run: begin
        if (start_ok) next_attempts = '0; // success ends the attempt count
        if (fault_active) begin
          unique case (mode)
            act_continue:  next_state = st_run;
            act_delay_off: begin
              next_state = st_delay;
              next_timer = span;
            end
            act_off_retry: next_state = st_off;
            act_hold_off:  next_state = st_hold;
          endcase
        end
      end
      st_delay: if (timer_done) next_state = st_off;
      st_off: begin
        if (retry_left) begin
          next_state = st_wait;
          next_timer = span;
        end else begin
          next_state = st_latched;
        end
      end
      st_wait: begin
        if (timer_done) begin
          next_state = st_run;
          if (!endless) next_attempts = 3'(attempts + 3'h1);
        end
      end
      st_hold:    if (!fault_active) next_state = st_run;
      st_latched: begin
        if (restart) begin
          next_state    = st_run;
          next_attempts = '0;
        end
      end
    endcase
    if (stop_now && state != st_latched) next_state = st_latched;
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      state     <= st_run;
      timer     <= '0;
      attempts  <= '0;
      output_on <= 1'b1;
      latched   <= 1'b0;
    end else begin
      state     <= next_state;
      timer     <= next_timer;
      attempts  <= next_attempts;
      output_on <= (next_state == st_run) || (next_state == st_delay);
      latched   <= (next_state == st_latched);
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);
  a_ignore_fault_run: assert property (
    state == st_run && mode == act_continue && !stop_now |=> output_on && state == st_run)
    else $error("continuous mode left the run state");
  a_delay_then_off: assert property (
    state == st_delay && timer_done && !stop_now |=> !output_on ##1 state == st_wait
      || state == st_latched)
    else $error("delay expiry did not disable the output");
  a_immediate_off: assert property (
    state == st_run && fault_active && mode == act_off_retry && !stop_now |=> !output_on)
    else $error("disable mode kept the output on");
  a_hold_release: assert property (
    state == st_hold && !fault_active && !stop_now |=> output_on)
    else $error("hold mode did not re-enable after the fault cleared");
  a_no_retry_latch: assert property (
    state == st_off && retry_set == `RETRY_NONE |=> latched && !output_on)
    else $error("no-retry setting did not latch off");
  a_retry_spacing: assert property (
    state == st_off && retry_left && !stop_now |=> state == st_wait && timer == $past(span))
    else $error("retry spacing not loaded from the time field");
  a_endless_count: assert property (
    state == st_wait && endless |=> $stable(attempts))
    else $error("endless retry changed the attempt count");
endmodule : fault_responder
`default_nettype wire

// [temperature_fault_supervisor.sv]
// temperature supervision: limit registers, sample comparison, sticky status, fault responses
// assumes a command port already decoded from the management bus, one command per cycle,
// and temperature samples in linear 11-bit format with a one-cycle valid strobe
// Operation
// - code 00 keeps the output running, fault bit still set
// - code 01 waits the time field delay, disables, then applies retry policy
// - code 10 disables at once, then retries per retry field
// - code 11 holds the output off while the fault lasts, then re-enables
// - retry 000 keeps the output off until the device restarts
// - retry 001 to 110 gives that many restarts, spaced by the time field
// - retry 111 restarts endlessly until disabled or another fault shuts down
// - the time field sets both the response delay and the restart spacing
// - every fault sets its status bit, cleared only by clear faults
// - above over-temperature warning limit: summary bit, warning bit, host alert
// - below under-temperature warning limit: summary bit, warning bit, host alert
// - below under-temperature fault limit: fault, then apply its response byte
// - under-temperature fault holds until temperature rises above its warning limit
// - both fault response registers reset to 80h
// - response registers are single bytes, limits are linear 11-bit words
// - over-temperature warning limit resets to EB70h, accepts 0 to 175 degrees
// - under-temperature limits reset to E4E0h and E490h, accept -55 to 25
// - over-temperature fault above its limit, cleared below the warning limit
`default_nettype none
`include "temperature_fault_supervisor_consts.svh"
module temperature_fault_supervisor #(
  parameter int unsigned OT_UNIT_CYCLES = `OT_TIME_UNIT_NS / `CLK_PERIOD_NS,
  parameter int unsigned UT_UNIT_CYCLES = `UT_TIME_UNIT_NS / `CLK_PERIOD_NS,
  parameter int          TIMER_WIDTH    = 24
) (
  input  wire logic                               clk,
  input  wire logic                               reset,
  input  wire logic                               cmd_valid,
  input  wire logic                               cmd_write,
  input  wire logic [7:0]                         cmd_code,
  input  wire temp_supervisor_pkg::l11_word_type  cmd_wdata,
  output var  temp_supervisor_pkg::l11_word_type  rd_data,
  output var  logic                               rd_valid,
  output var  logic                               cmd_refused,
  input  wire logic                               temp_valid,
  input  wire temp_supervisor_pkg::l11_word_type  temp_sample,
  input  wire logic                               clear_faults,
  input  wire logic                               restart,
  input  wire logic                               rail_disable,
  input  wire logic                               start_ok,
  output var  logic                               output_enable,
  output var  logic [7:0]                         status_temperature,
  output var  logic                               temp_summary,
  output var  logic                               host_alert
);
  import temp_supervisor_pkg::*;

  // l11 word to signed fixed point with FIXED_FRAC_BITS fraction bits
  function automatic fixed_temp_type to_fixed(input l11_word_type w);
    logic signed [4:0]  e;
    logic signed [10:0] m;
    logic [5:0]         sh;
    fixed_temp_type     v;
    e  = w[15:11];
    m  = w[10:0];
    sh = 6'(int'(e) + `FIXED_FRAC_BITS);
    v  = m;
    v  = v <<< sh;
    return v;
  endfunction : to_fixed

  function automatic logic in_range(input fixed_temp_type v, input int lo, input int hi);
    fixed_temp_type lo_fx;
    fixed_temp_type hi_fx;
    lo_fx = fixed_temp_type'(lo) <<< `FIXED_FRAC_BITS;
    hi_fx = fixed_temp_type'(hi) <<< `FIXED_FRAC_BITS;
    return (v >= lo_fx) && (v <= hi_fx);
  endfunction : in_range

  l11_word_type overtemp_fault_threshold;
  l11_word_type overtemp_warning_threshold;
  l11_word_type undertemp_warning_threshold;
  l11_word_type undertemp_fault_threshold;
  logic [7:0]   overtemp_fault_action;
  logic [7:0]   undertemp_fault_action;
  logic         ot_fault_active;
  logic         ut_fault_active;
  logic         ot_on;
  logic         ut_on;
  logic         ot_latched;
  logic         ut_latched;

  // command decode
  wire logic hit_ot_fault_thr  = (cmd_code == `CMD_OT_FAULT_THR);
  wire logic hit_ot_action     = (cmd_code == `CMD_OT_FAULT_ACTION);
  wire logic hit_ot_warn_thr   = (cmd_code == `CMD_OT_WARN_THR);
  wire logic hit_ut_warn_thr   = (cmd_code == `CMD_UT_WARN_THR);
  wire logic hit_ut_fault_thr  = (cmd_code == `CMD_UT_FAULT_THR);
  wire logic hit_ut_action     = (cmd_code == `CMD_UT_FAULT_ACTION);
  wire logic hit_any           = hit_ot_fault_thr | hit_ot_action | hit_ot_warn_thr
                               | hit_ut_warn_thr | hit_ut_fault_thr | hit_ut_action;
  wire fixed_temp_type wdata_fixed = to_fixed(cmd_wdata);
  wire logic ot_range_ok = in_range(wdata_fixed, `OT_RANGE_MIN_C, `OT_RANGE_MAX_C);
  wire logic ut_range_ok = in_range(wdata_fixed, `UT_RANGE_MIN_C, `UT_RANGE_MAX_C);
  // limit words outside their range are refused and leave the register alone
  wire logic range_ok = (hit_ot_fault_thr | hit_ot_warn_thr) ? ot_range_ok :
                        (hit_ut_warn_thr | hit_ut_fault_thr) ? ut_range_ok :
                        1'b1;
  wire logic wr_go = cmd_valid & cmd_write & range_ok;
  wire logic rd_go = cmd_valid & ~cmd_write & hit_any;
  wire logic next_refused = cmd_valid & (~hit_any | (cmd_write & ~range_ok));

  // byte registers read back in the low byte, upper byte zero
  wire l11_word_type rd_mux =
    hit_ot_fault_thr ? overtemp_fault_threshold :
    hit_ot_action    ? {8'h00, overtemp_fault_action} :
    hit_ot_warn_thr  ? overtemp_warning_threshold :
    hit_ut_warn_thr  ? undertemp_warning_threshold :
    hit_ut_fault_thr ? undertemp_fault_threshold :
    hit_ut_action    ? {8'h00, undertemp_fault_action} :
    16'h0000;

  always_ff @(posedge clk) begin
    if (reset) begin
      overtemp_fault_threshold    <= `RST_OT_FAULT_THR;
      overtemp_warning_threshold  <= `RST_OT_WARN_THR;
      undertemp_warning_threshold <= `RST_UT_WARN_THR;
      undertemp_fault_threshold   <= `RST_UT_FAULT_THR;
      overtemp_fault_action       <= `RST_FAULT_ACTION;
      undertemp_fault_action      <= `RST_FAULT_ACTION;
    end else if (wr_go) begin
      if (hit_ot_fault_thr) overtemp_fault_threshold    <= cmd_wdata;
      if (hit_ot_warn_thr)  overtemp_warning_threshold  <= cmd_wdata;
      if (hit_ut_warn_thr)  undertemp_warning_threshold <= cmd_wdata;
      if (hit_ut_fault_thr) undertemp_fault_threshold   <= cmd_wdata;
      if (hit_ot_action)    overtemp_fault_action       <= cmd_wdata[7:0];
      if (hit_ut_action)    undertemp_fault_action      <= cmd_wdata[7:0];
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      rd_data     <= 16'h0000;
      rd_valid    <= 1'b0;
      cmd_refused <= 1'b0;
    end else begin
      rd_data     <= rd_go ? rd_mux : rd_data;
      rd_valid    <= rd_go;
      cmd_refused <= next_refused;
    end
  end

  // comparison of each sample with all four limits
  wire fixed_temp_type sample_fixed   = to_fixed(temp_sample);
  wire fixed_temp_type ot_fault_fixed = to_fixed(overtemp_fault_threshold);
  wire fixed_temp_type ot_warn_fixed  = to_fixed(overtemp_warning_threshold);
  wire fixed_temp_type ut_warn_fixed  = to_fixed(undertemp_warning_threshold);
  wire fixed_temp_type ut_fault_fixed = to_fixed(undertemp_fault_threshold);
  wire logic above_ot_fault = temp_valid && (sample_fixed > ot_fault_fixed);
  wire logic below_ot_warn  = temp_valid && (sample_fixed < ot_warn_fixed);
  wire logic above_ot_warn  = temp_valid && (sample_fixed > ot_warn_fixed);
  wire logic below_ut_warn  = temp_valid && (sample_fixed < ut_warn_fixed);
  wire logic above_ut_warn  = temp_valid && (sample_fixed > ut_warn_fixed);
  wire logic below_ut_fault = temp_valid && (sample_fixed < ut_fault_fixed);

  // fault levels with hysteresis against the warning limits; a new crossing wins
  wire logic next_ot_fault = above_ot_fault | (ot_fault_active & ~below_ot_warn);
  wire logic next_ut_fault = below_ut_fault | (ut_fault_active & ~above_ut_warn);

  always_ff @(posedge clk) begin
    if (reset) begin
      ot_fault_active <= 1'b0;
      ut_fault_active <= 1'b0;
    end else begin
      ot_fault_active <= next_ot_fault;
      ut_fault_active <= next_ut_fault;
    end
  end

  // sticky status: a set in the clearing cycle survives
  logic [7:0] status_set;
  always_comb begin
    status_set                   = 8'h00;
    status_set[`ST_OT_FAULT_BIT] = ot_fault_active;
    status_set[`ST_OT_WARN_BIT]  = above_ot_warn;
    status_set[`ST_UT_WARN_BIT]  = below_ut_warn;
    status_set[`ST_UT_FAULT_BIT] = ut_fault_active;
  end
  wire logic [7:0] next_status = status_set | (status_temperature & {8{~clear_faults}});
  wire logic       next_summary = |next_status;

  always_ff @(posedge clk) begin
    if (reset) begin
      status_temperature <= 8'h00;
      temp_summary       <= 1'b0;
      host_alert         <= 1'b0;
    end else begin
      status_temperature <= next_status;
      temp_summary       <= next_summary;
      host_alert         <= next_summary;
    end
  end

  fault_responder #(
    .UNIT_CYCLES (OT_UNIT_CYCLES),
    .CNT_W       (TIMER_WIDTH)
  ) ot_responder (
    .clk           (clk),
    .reset         (reset),
    .action        (overtemp_fault_action),
    .fault_active  (ot_fault_active),
    .restart       (restart),
    .rail_disable  (rail_disable),
    .other_latched (ut_latched),
    .start_ok      (start_ok),
    .output_on     (ot_on),
    .latched       (ot_latched)
  );

  fault_responder #(
    .UNIT_CYCLES (UT_UNIT_CYCLES),
    .CNT_W       (TIMER_WIDTH)
  ) ut_responder (
    .clk           (clk),
    .reset         (reset),
    .action        (undertemp_fault_action),
    .fault_active  (ut_fault_active),
    .restart       (restart),
    .rail_disable  (rail_disable),
    .other_latched (ot_latched),
    .start_ok      (start_ok),
    .output_on     (ut_on),
    .latched       (ut_latched)
  );

  always_ff @(posedge clk) begin
    if (reset) begin
      output_enable <= 1'b1;
    end else begin
      output_enable <= ot_on & ut_on;
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);

  a_fault_bit_sticky: assert property (
    status_temperature[`ST_OT_FAULT_BIT] && !clear_faults
      |=> status_temperature[`ST_OT_FAULT_BIT])
    else $error("fault status bit dropped without clear faults");
  a_ot_warn_flag: assert property (
    above_ot_warn |=> status_temperature[`ST_OT_WARN_BIT] && temp_summary && host_alert)
    else $error("over-temperature warning not flagged");
  a_ut_warn_flag: assert property (
    below_ut_warn |=> status_temperature[`ST_UT_WARN_BIT] && temp_summary && host_alert)
    else $error("under-temperature warning not flagged");
  a_ut_hysteresis: assert property (
    ut_fault_active && !above_ut_warn |=> ut_fault_active)
    else $error("under-temperature fault cleared before warning limit");
  a_ot_fault_set: assert property (
    above_ot_fault |=> ot_fault_active ##1 status_temperature[`ST_OT_FAULT_BIT])
    else $error("over-temperature fault not declared");
  a_limit_range: assert property (
    cmd_valid && cmd_write && hit_ot_warn_thr && !ot_range_ok
      |=> cmd_refused && $stable(overtemp_warning_threshold))
    else $error("out of range limit write was taken");
  a_action_reset: assert property (
    disable iff (1'b0) reset |=> overtemp_fault_action == `RST_FAULT_ACTION
      && undertemp_fault_action == `RST_FAULT_ACTION)
    else $error("fault response registers not at reset value");
  a_read_byte: assert property (
    cmd_valid && !cmd_write && hit_ut_action |=> rd_valid && rd_data[15:8] == 8'h00)
    else $error("byte register read returned upper bits");

  c_ot_shutdown: cover property (ot_fault_active ##[1:4] !output_enable);
  c_ut_warn_then_fault: cover property (below_ut_warn ##[1:20] ut_fault_active);
  c_clear_after_fault: cover property (status_temperature[`ST_UT_FAULT_BIT] ##1 clear_faults);
endmodule : temperature_fault_supervisor
`default_nettype wire

// [host_model.sv]
// host side of the register port: issues one command at a time, reports the answer
// assumes the bench clock and the one-cycle answer timing of the supervisor
`default_nettype none
module host_model (
  input  wire logic        clk,
  output var  logic        cmd_valid,
  output var  logic        cmd_write,
  output var  logic [7:0]  cmd_code,
  output var  logic [15:0] cmd_wdata,
  input  wire logic [15:0] rd_data,
  input  wire logic        rd_valid,
  input  wire logic        cmd_refused
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    cmd_valid = 1'b0;
    cmd_write = 1'b0;
    cmd_code  = 8'h00;
    cmd_wdata = 16'h0000;
  end
  // whole word per command; byte commands carry the byte in bits 7:0
  task access(input logic wr, input logic [7:0] code, input logic [15:0] wdata,
              output logic [15:0] rdata, output logic [1:0] flags);
    @(posedge clk);
    #1;
    cmd_valid = 1'b1;
    cmd_write = wr;
    cmd_code  = code;
    cmd_wdata = wdata;
    @(posedge clk);
    #1;
    // released code and data lines show the inverse so stale values never look valid
    cmd_valid = 1'b0;
    cmd_code  = ~cmd_code;
    cmd_wdata = ~cmd_wdata;
    rdata     = rd_data;
    flags     = {rd_valid, cmd_refused};
  endtask : access
endmodule : host_model
`default_nettype wire

// [temperature_fault_supervisor_tb.sv]
// self-checking bench of the temperature fault supervisor
// assumes host_model for commands; short time unit keeps delays to a few cycles
`default_nettype none
module temperature_fault_supervisor_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clk = 1'b0, reset = 1'b1, temp_valid = 1'b0, clear_faults = 1'b0;
  logic        restart = 1'b0, rail_disable = 1'b0, start_ok = 1'b0;
  logic [15:0] temp_sample = 16'h0000, rd_data, cmd_wdata, d;
  logic [7:0]  cmd_code, status_temperature;
  logic [1:0]  f;
  logic        cmd_valid, cmd_write, rd_valid, cmd_refused, output_enable;
  logic        temp_summary, host_alert;
  int          mismatches = 0, checked = 0;
  logic [7:0]  codes [6] = '{8'h4f, 8'h50, 8'h51, 8'h52, 8'h53, 8'h54};
  logic [15:0] resets [6] = '{16'hebe8, 16'h0080, 16'heb70, 16'he4e0, 16'he490, 16'h0080};
  always #5 clk = ~clk;
  host_model u_host (.clk(clk), .cmd_valid(cmd_valid), .cmd_write(cmd_write),
    .cmd_code(cmd_code), .cmd_wdata(cmd_wdata), .rd_data(rd_data), .rd_valid(rd_valid),
    .cmd_refused(cmd_refused));
  temperature_fault_supervisor #(.OT_UNIT_CYCLES(4), .UT_UNIT_CYCLES(4)) u_dut (
    .clk(clk), .reset(reset), .cmd_valid(cmd_valid), .cmd_write(cmd_write),
    .cmd_code(cmd_code), .cmd_wdata(cmd_wdata), .rd_data(rd_data), .rd_valid(rd_valid),
    .cmd_refused(cmd_refused), .temp_valid(temp_valid), .temp_sample(temp_sample),
    .clear_faults(clear_faults), .restart(restart), .rail_disable(rail_disable),
    .start_ok(start_ok), .output_enable(output_enable),
    .status_temperature(status_temperature), .temp_summary(temp_summary),
    .host_alert(host_alert));
  task print_verdict;
    $display("checked=%0d mismatches=%0d", checked, mismatches);
    if (mismatches == 0 && checked > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : print_verdict
  task chk(input logic [15:0] got, input logic [15:0] exp);
    checked++;
    if (got !== exp) begin
      mismatches++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task cycles(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : cycles
  task do_reset;
    cycles(1);
    reset = 1'b1;
    cycles(16);
    reset = 1'b0;
  endtask : do_reset
  task sample(input logic [15:0] t);
    cycles(1);
    temp_valid  = 1'b1;
    temp_sample = t;
    cycles(1);
    temp_valid  = 1'b0;
    temp_sample = ~t;
  endtask : sample
  task pulse(input logic clr);
    cycles(1);
    clear_faults = clr;
    restart      = ~clr;
    cycles(1);
    clear_faults = 1'b0;
    restart      = 1'b0;
  endtask : pulse
  task wait_oe(input logic exp, input int bound);
    int i;
    for (i = 0; i < bound && output_enable !== exp; i++) cycles(1);
    chk({15'h0, output_enable}, {15'h0, exp});
    if (output_enable !== exp) print_verdict();
  endtask : wait_oe
  task wr(input logic [7:0] code, input logic [15:0] v, input logic [1:0] ef);
    u_host.access(1'b1, code, v, d, f);
    chk({14'h0, f}, {14'h0, ef});
  endtask : wr
  initial begin
    do_reset();
    for (int k = 0; k < 6; k++) begin
      u_host.access(1'b0, codes[k], 16'h0000, d, f);
      chk(d, resets[k]);
      chk({14'h0, f}, 16'h0002);
    end
    u_host.access(1'b0, 8'h55, 16'h0000, d, f);
    chk({14'h0, f}, 16'h0001);
    wr(8'h51, 16'hf2d0, 2'b01);
    wr(8'h51, 16'heb20, 2'b00);
    wr(8'h50, 16'hff80, 2'b00);
    u_host.access(1'b0, 8'h51, 16'h0000, d, f);
    chk(d, 16'heb20);
    u_host.access(1'b0, 8'h50, 16'h0000, d, f);
    chk(d, 16'h0080);
    // 130 C: over both the fault and the 100 C warning limit
    sample(16'hf208);
    cycles(3);
    chk({8'h0, status_temperature}, 16'h00c0);
    chk({14'h0, temp_summary, host_alert}, 16'h0003);
    chk({15'h0, output_enable}, 16'h0000);
    sample(16'he8a0);
    cycles(10);
    chk({7'h0, output_enable, status_temperature}, 16'h00c0);
    pulse(1'b1);
    cycles(1);
    chk({8'h0, status_temperature}, 16'h0000);
    pulse(1'b0);
    wait_oe(1'b1, 20);
    // ignore mode: cold fault flagged, output kept running
    do_reset();
    wr(8'h54, 16'h0000, 2'b00);
    sample(16'hee20);
    cycles(3);
    chk({7'h0, output_enable, status_temperature}, 16'h0130);
    // hold-off mode with hysteresis up to the warning limit
    do_reset();
    wr(8'h54, 16'h00c0, 2'b00);
    sample(16'hee20);
    wait_oe(1'b0, 10);
    sample(16'hee60);
    cycles(10);
    chk({15'h0, output_enable}, 16'h0000);
    sample(16'he8a0);
    wait_oe(1'b1, 10);
    // delayed disable: time field 2, unit 4 cycles
    do_reset();
    wr(8'h50, 16'h004a, 2'b00);
    sample(16'hf208);
    cycles(3);
    chk({15'h0, output_enable}, 16'h0001);
    wait_oe(1'b0, 20);
    // one restart allowed: back on after the spacing, then off for good
    wait_oe(1'b1, 20);
    wait_oe(1'b0, 20);
    cycles(30);
    chk({15'h0, output_enable}, 16'h0000);
    // endless restarts: more attempts than any counted setting allows
    do_reset();
    wr(8'h50, 16'h00b9, 2'b00);
    sample(16'hf208);
    wait_oe(1'b0, 10);
    for (int n = 0; n < 8; n++) begin
      wait_oe(1'b1, 20);
      wait_oe(1'b0, 20);
    end
    // disabling the rail ends the endless restarts
    rail_disable = 1'b1;
    cycles(2);
    repeat (10) begin
      cycles(1);
      chk({15'h0, output_enable}, 16'h0000);
    end
    rail_disable = 1'b0;
    print_verdict();
  end
endmodule : temperature_fault_supervisor_tb
`default_nettype wire
